// >>> hw/dma_flow_pkg.sv
// constants, field layouts and states shared by the dma channel and its link partner
package dma_flow_pkg;
  localparam int DW = 32;
  localparam int PAW = 8;
  localparam int CNT_W = 16;
  localparam int WAIT_W = 5;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [PAW-1:0] OFF_CTRL = 8'h00;
  localparam logic [PAW-1:0] OFF_SRC_ADDR = 8'h04;
  localparam logic [PAW-1:0] OFF_DST_ADDR = 8'h08;
  localparam logic [PAW-1:0] OFF_DESC_PTR = 8'h0c;
  localparam logic [PAW-1:0] OFF_CFG = 8'h10;
  localparam logic [PAW-1:0] OFF_SIZE = 8'h14;
  localparam logic [PAW-1:0] OFF_SWREQ = 8'h18;
  localparam logic [PAW-1:0] OFF_STATUS = 8'h1c;

  // ----------------------------------------------------------------------
  // field positions
  // ----------------------------------------------------------------------
  localparam int CTRL_EN_BIT = 0;
  localparam int CFG_SRC_MODE_LSB = 0;
  localparam int CFG_DST_MODE_LSB = 2;
  localparam int CFG_SRC_HS_BIT = 4;
  localparam int CFG_DST_HS_BIT = 5;
  localparam int CFG_SRC_PERIPH_BIT = 6;
  localparam int CFG_DST_PERIPH_BIT = 7;
  localparam int CFG_CH_LOCK_BIT = 8;
  localparam int CFG_CH_SCOPE_LSB = 9;
  localparam int CFG_BUS_LOCK_BIT = 11;
  localparam int CFG_BUS_SCOPE_LSB = 12;
  localparam int SIZE_BUF_LEN_LSB = 0;
  localparam int SIZE_CHUNK_LSB = 16;
  localparam int SIZE_BUF_TOTAL_LSB = 24;
  localparam int SWREQ_SRC_BIT = 0;
  localparam int SWREQ_DST_BIT = 1;
  localparam int STAT_BUSY_BIT = 0;
  localparam int STAT_DONE_BIT = 1;
  localparam int STAT_BUF_LSB = 8;

  localparam logic [DW-1:0] REG_RESET = 32'h0;
  localparam logic [DW-1:0] WORD_BYTES = 32'h4;

  // ----------------------------------------------------------------------
  // encodings
  // ----------------------------------------------------------------------
  localparam logic [1:0] MB_RELOAD = 2'h0;
  localparam logic [1:0] MB_CONTIG = 2'h1;
  localparam logic [1:0] MB_CHAIN = 2'h2;
  localparam logic [1:0] SCOPE_TRANSFER = 2'h0;
  localparam logic [1:0] SCOPE_BUFFER = 2'h1;
  localparam logic [1:0] SCOPE_CHUNK = 2'h2;
  localparam logic [1:0] HTRANS_IDLE = 2'h0;
  localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
  // linked list item: src address, dst address, next descriptor pointer
  localparam logic [1:0] ITEM_LAST = 2'h2;

  typedef enum logic [2:0] {
    ST_IDLE, ST_FETCH, ST_WAIT_REQ, ST_READ, ST_WRITE, ST_CHUNK_END, ST_BUF_END
  } chan_state_t;
endpackage

// >>> hw/dma_link_if.sv
// link between the dma channel and the slave/peripheral it serves
`timescale 1ns/1ps
interface dma_link_if;
  logic [1:0] htrans;
  logic [31:0] haddr;
  logic hwrite;
  logic [31:0] hwdata;
  logic [31:0] hrdata;
  logic hready;
  logic hmastlock;
  logic src_req;
  logic dst_req;
  logic src_ack;
  logic dst_ack;

  modport ctrl_end (
    output htrans, haddr, hwrite, hwdata, hmastlock, src_ack, dst_ack,
    input hrdata, hready, src_req, dst_req
  );
  modport periph_end (
    input htrans, haddr, hwrite, hwdata, hmastlock, src_ack, dst_ack,
    output hrdata, hready, src_req, dst_req
  );
endinterface

// >>> hw/dma_channel_flow_control.sv
// one dma channel: apb registers, multi-buffer sequencing, locking and handshake gating
`timescale 1ns/1ps
module dma_channel_flow_control (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [dma_flow_pkg::PAW-1:0] paddr,
  input wire logic [dma_flow_pkg::DW-1:0] pwdata,
  output logic [dma_flow_pkg::DW-1:0] prdata,
  output logic pready,
  output logic pslverr,
  dma_link_if.ctrl_end link,
  output logic arb_lock
);
  import dma_flow_pkg::*;

  // ----------------------------------------------------------------------
  // registers and state
  // ----------------------------------------------------------------------
  chan_state_t state_reg;
  logic [DW-1:0] src_addr_reg, dst_addr_reg, desc_ptr_reg, cfg_reg, size_reg;
  logic [DW-1:0] cur_src_reg, cur_dst_reg, next_desc_ptr_reg, data_reg, prdata_reg;
  logic [CNT_W-1:0] word_cnt_reg, chunk_cnt_reg;
  logic [7:0] buf_cnt_reg;
  logic [1:0] item_idx_reg;
  logic swreq_src_reg, swreq_dst_reg, done_reg;

  logic wr_en, addr_ok, start, bus_done, busy;
  logic [1:0] src_mode, dst_mode;
  logic src_hw, dst_hw, src_periph, dst_periph, any_chain;
  logic src_ok, dst_ok, chunk_last, buf_last, buf_done, xfer_last;
  logic [CNT_W-1:0] buf_len, chunk_len;
  logic [7:0] buf_total;

  assign src_mode = cfg_reg[CFG_SRC_MODE_LSB +: 2];
  assign dst_mode = cfg_reg[CFG_DST_MODE_LSB +: 2];
  assign src_hw = cfg_reg[CFG_SRC_HS_BIT];
  assign dst_hw = cfg_reg[CFG_DST_HS_BIT];
  assign src_periph = cfg_reg[CFG_SRC_PERIPH_BIT];
  assign dst_periph = cfg_reg[CFG_DST_PERIPH_BIT];
  assign any_chain = (src_mode == MB_CHAIN) | (dst_mode == MB_CHAIN);
  assign buf_len = size_reg[SIZE_BUF_LEN_LSB +: CNT_W];
  assign chunk_len = {8'h0, size_reg[SIZE_CHUNK_LSB +: 8]};
  assign buf_total = size_reg[SIZE_BUF_TOTAL_LSB +: 8];
  assign busy = (state_reg != ST_IDLE);

  // ----------------------------------------------------------------------
  // apb slave: zero wait states, error on unmapped offsets
  // ----------------------------------------------------------------------
  assign wr_en = psel & penable & pwrite;
  assign pready = 1'b1;
  assign addr_ok = (paddr == OFF_CTRL) | (paddr == OFF_SRC_ADDR) | (paddr == OFF_DST_ADDR) |
                   (paddr == OFF_DESC_PTR) | (paddr == OFF_CFG) | (paddr == OFF_SIZE) |
                   (paddr == OFF_SWREQ) | (paddr == OFF_STATUS);
  assign pslverr = psel & penable & ~addr_ok;
  assign prdata = prdata_reg;
  assign start = wr_en & (paddr == OFF_CTRL) & pwdata[CTRL_EN_BIT] & ~busy;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_addr_reg <= REG_RESET;
      dst_addr_reg <= REG_RESET;
      desc_ptr_reg <= REG_RESET;
      cfg_reg <= REG_RESET;
      size_reg <= REG_RESET;
    end else if (wr_en) begin
      case (paddr)
        OFF_SRC_ADDR: src_addr_reg <= pwdata;
        OFF_DST_ADDR: dst_addr_reg <= pwdata;
        OFF_DESC_PTR: desc_ptr_reg <= pwdata;
        OFF_CFG: cfg_reg <= pwdata;
        OFF_SIZE: size_reg <= pwdata;
        default: ;
      endcase
    end
  end

  // read data is latched in the setup cycle so it stands through the access cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_reg <= REG_RESET;
    end else if (psel & ~penable & ~pwrite) begin
      case (paddr)
        OFF_CTRL: prdata_reg <= {31'h0, busy};
        OFF_SRC_ADDR: prdata_reg <= src_addr_reg;
        OFF_DST_ADDR: prdata_reg <= dst_addr_reg;
        OFF_DESC_PTR: prdata_reg <= desc_ptr_reg;
        OFF_CFG: prdata_reg <= cfg_reg;
        OFF_SIZE: prdata_reg <= size_reg;
        OFF_SWREQ: prdata_reg <= {30'h0, swreq_dst_reg, swreq_src_reg};
        OFF_STATUS: prdata_reg <= {16'h0, buf_cnt_reg, 6'h0, done_reg, busy};
        default: prdata_reg <= REG_RESET;
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // software handshake requests and done flag: set wins over clear
  // ----------------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      swreq_src_reg <= 1'b0;
      swreq_dst_reg <= 1'b0;
    end else begin
      if (wr_en & (paddr == OFF_SWREQ) & pwdata[SWREQ_SRC_BIT]) begin
        swreq_src_reg <= 1'b1;
      end else if (state_reg == ST_CHUNK_END & src_periph & ~src_hw) begin
        swreq_src_reg <= 1'b0;
      end
      if (wr_en & (paddr == OFF_SWREQ) & pwdata[SWREQ_DST_BIT]) begin
        swreq_dst_reg <= 1'b1;
      end else if (state_reg == ST_CHUNK_END & dst_periph & ~dst_hw) begin
        swreq_dst_reg <= 1'b0;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      done_reg <= 1'b0;
    end else if (state_reg == ST_BUF_END & xfer_last) begin
      done_reg <= 1'b1;
    end else if (wr_en & (paddr == OFF_STATUS) & pwdata[STAT_DONE_BIT]) begin
      done_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------------
  // sequencing
  // ----------------------------------------------------------------------
  assign bus_done = (link.htrans == HTRANS_NONSEQ) & link.hready;
  // memory-type sides never wait; peripherals wait on their chosen handshake
  assign src_ok = ~src_periph | (src_hw ? link.src_req : swreq_src_reg);
  assign dst_ok = ~dst_periph | (dst_hw ? link.dst_req : swreq_dst_reg);
  // zero lengths behave as one word
  assign chunk_last = (chunk_cnt_reg + 16'h1) >= chunk_len;
  assign buf_last = (word_cnt_reg + 16'h1) >= buf_len;
  assign buf_done = word_cnt_reg >= buf_len;
  assign xfer_last = ((buf_cnt_reg + 8'h1) >= buf_total) |
                     (any_chain & next_desc_ptr_reg == REG_RESET);

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_reg <= ST_IDLE;
    end else begin
      case (state_reg)
        ST_IDLE: if (start) state_reg <= any_chain ? ST_FETCH : ST_WAIT_REQ;
        ST_FETCH: if (bus_done & item_idx_reg == ITEM_LAST) state_reg <= ST_WAIT_REQ;
        ST_WAIT_REQ: if (src_ok & dst_ok) state_reg <= ST_READ;
        ST_READ: if (bus_done) state_reg <= ST_WRITE;
        ST_WRITE: if (bus_done) state_reg <= (chunk_last | buf_last) ? ST_CHUNK_END : ST_READ;
        ST_CHUNK_END: state_reg <= buf_done ? ST_BUF_END : ST_WAIT_REQ;
        ST_BUF_END: begin
          if (xfer_last) begin
            state_reg <= ST_IDLE;
          end else begin
            state_reg <= any_chain ? ST_FETCH : ST_WAIT_REQ;
          end
        end
        default: state_reg <= ST_IDLE;
      endcase
    end
  end

  // addresses: chained items override, reload restores, contiguous just runs on
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cur_src_reg <= REG_RESET;
      cur_dst_reg <= REG_RESET;
      next_desc_ptr_reg <= REG_RESET;
    end else begin
      if (state_reg == ST_IDLE & start) begin
        cur_src_reg <= src_addr_reg;
        cur_dst_reg <= dst_addr_reg;
        next_desc_ptr_reg <= desc_ptr_reg;
      end else if (state_reg == ST_FETCH & bus_done) begin
        if (item_idx_reg == 2'h0 & src_mode == MB_CHAIN) cur_src_reg <= link.hrdata;
        if (item_idx_reg == 2'h1 & dst_mode == MB_CHAIN) cur_dst_reg <= link.hrdata;
        if (item_idx_reg == ITEM_LAST) next_desc_ptr_reg <= link.hrdata;
      end else if (state_reg == ST_WRITE & bus_done) begin
        // a peripheral sits at one fixed address
        if (!src_periph) cur_src_reg <= cur_src_reg + WORD_BYTES;
        if (!dst_periph) cur_dst_reg <= cur_dst_reg + WORD_BYTES;
      end else if (state_reg == ST_BUF_END & ~xfer_last) begin
        if (src_mode == MB_RELOAD) cur_src_reg <= src_addr_reg;
        if (dst_mode == MB_RELOAD) cur_dst_reg <= dst_addr_reg;
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      data_reg <= REG_RESET;
    end else if (state_reg == ST_READ & bus_done) begin
      data_reg <= link.hrdata;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      word_cnt_reg <= '0;
      chunk_cnt_reg <= '0;
      buf_cnt_reg <= 8'h0;
      item_idx_reg <= 2'h0;
    end else begin
      if (start | state_reg == ST_BUF_END) begin
        word_cnt_reg <= '0;
      end else if (state_reg == ST_WRITE & bus_done) begin
        word_cnt_reg <= word_cnt_reg + 16'h1;
      end
      if (start | state_reg == ST_CHUNK_END) begin
        chunk_cnt_reg <= '0;
      end else if (state_reg == ST_WRITE & bus_done) begin
        chunk_cnt_reg <= chunk_cnt_reg + 16'h1;
      end
      if (start) begin
        buf_cnt_reg <= 8'h0;
      end else if (state_reg == ST_BUF_END) begin
        buf_cnt_reg <= buf_cnt_reg + 8'h1;
      end
      if (state_reg == ST_FETCH & bus_done) begin
        item_idx_reg <= (item_idx_reg == ITEM_LAST) ? 2'h0 : item_idx_reg + 2'h1;
      end
    end
  end

  // ----------------------------------------------------------------------
  // link drive
  // ----------------------------------------------------------------------
  always_comb begin
    link.htrans = HTRANS_IDLE;
    link.haddr = cur_dst_reg;
    case (state_reg)
      ST_FETCH: begin
        link.htrans = HTRANS_NONSEQ;
        link.haddr = next_desc_ptr_reg + {28'h0, item_idx_reg, 2'h0};
      end
      ST_READ: begin
        link.htrans = HTRANS_NONSEQ;
        link.haddr = cur_src_reg;
      end
      ST_WRITE: link.htrans = HTRANS_NONSEQ;
      default: ;
    endcase
  end
  assign link.hwrite = (state_reg == ST_WRITE);
  assign link.hwdata = data_reg;
  assign link.src_ack = (state_reg == ST_CHUNK_END) & src_periph & src_hw;
  assign link.dst_ack = (state_reg == ST_CHUNK_END) & dst_periph & dst_hw;

  // ----------------------------------------------------------------------
  // locking: buffer scope drops for the buffer-end cycle, chunk scope outside data beats
  // ----------------------------------------------------------------------
  function automatic logic in_scope(input logic [1:0] scope, input chan_state_t st);
    case (scope)
      SCOPE_TRANSFER: in_scope = (st != ST_IDLE);
      SCOPE_BUFFER: in_scope = (st != ST_IDLE) & (st != ST_BUF_END);
      SCOPE_CHUNK: in_scope = (st == ST_READ) | (st == ST_WRITE);
      default: in_scope = 1'b0;
    endcase
  endfunction

  assign link.hmastlock = cfg_reg[CFG_BUS_LOCK_BIT] &
                          in_scope(cfg_reg[CFG_BUS_SCOPE_LSB +: 2], state_reg);
  // or-ing the bus lock in keeps arbitration at least as long as hmastlock
  assign arb_lock = (cfg_reg[CFG_CH_LOCK_BIT] &
                     in_scope(cfg_reg[CFG_CH_SCOPE_LSB +: 2], state_reg)) |
                    link.hmastlock;
endmodule

// >>> hw/dma_periph_end.sv
// slave side of the link: word memory with wait states and request lines
`timescale 1ns/1ps
module dma_periph_end #(
  parameter int DEPTH = 16,
  parameter int WAIT_STATES = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  dma_link_if.periph_end link,
  input wire logic hw_mode,
  input wire logic src_want,
  input wire logic dst_want,
  output logic irq
);
  import dma_flow_pkg::*;

  localparam int IDX_W = $clog2(DEPTH);

  logic [DW-1:0] mem_reg [DEPTH];
  logic [WAIT_W-1:0] wait_cnt_reg, wait_target;
  logic src_req_reg, dst_req_reg, active, access;
  logic [IDX_W-1:0] idx;

  assign active = (link.htrans == HTRANS_NONSEQ);
  assign idx = link.haddr[IDX_W+1:2];
  // with hardware handshake the request already signals readiness, so no stall
  assign wait_target = hw_mode ? '0 : WAIT_W'(WAIT_STATES);
  assign link.hready = active ? (wait_cnt_reg == wait_target) : 1'b1;
  assign access = active & link.hready;
  assign link.hrdata = mem_reg[idx];

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wait_cnt_reg <= '0;
    end else if (access | ~active) begin
      wait_cnt_reg <= '0;
    end else begin
      wait_cnt_reg <= wait_cnt_reg + 5'h1;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (int i = 0; i < DEPTH; i++) mem_reg[i] <= REG_RESET;
    end else if (access & link.hwrite) begin
      mem_reg[idx] <= link.hwdata;
    end
  end

  // requests are raised before any access; set wins over the clearing event
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      src_req_reg <= 1'b0;
      dst_req_reg <= 1'b0;
    end else begin
      if (src_want) begin
        src_req_reg <= 1'b1;
      end else if (hw_mode ? link.src_ack : (access & ~link.hwrite)) begin
        src_req_reg <= 1'b0;
      end
      if (dst_want) begin
        dst_req_reg <= 1'b1;
      end else if (hw_mode ? link.dst_ack : (access & link.hwrite)) begin
        dst_req_reg <= 1'b0;
      end
    end
  end

  assign link.src_req = src_req_reg & hw_mode;
  assign link.dst_req = dst_req_reg & hw_mode;
  assign irq = (src_req_reg | dst_req_reg) & ~hw_mode;
endmodule

// >>> dv/dma_flow_chk.sv
// concurrent checks on the link between the dma channel and the peripheral end
`timescale 1ns/1ps
module dma_flow_chk (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [1:0] htrans,
  input wire logic [31:0] haddr,
  input wire logic hwrite,
  input wire logic hready,
  input wire logic hmastlock,
  input wire logic src_req,
  input wire logic dst_req,
  input wire logic src_ack,
  input wire logic dst_ack,
  input wire logic arb_lock
);
  import dma_flow_pkg::*;
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  logic stall;
  assign stall = (htrans == HTRANS_NONSEQ) && !hready;

  chk_beat_held: assert property (
    stall |=> htrans == HTRANS_NONSEQ && $stable(haddr) && $stable(hwrite))
    else $error("link beat changed while stalled");
  chk_wait_bound: assert property (
    stall |-> ##[1:16] hready)
    else $error("slave stalled more than sixteen cycles");
  chk_bus_arb_lock: assert property (
    hmastlock |-> arb_lock)
    else $error("bus lock without arbitration lock");
  chk_src_ack_pulse: assert property (
    src_ack |=> !src_ack)
    else $error("source ack longer than one cycle");
  chk_dst_ack_pulse: assert property (
    dst_ack |=> !dst_ack)
    else $error("dest ack longer than one cycle");
  chk_src_ack_req: assert property (
    src_ack |-> src_req ##1 !src_req)
    else $error("source ack without request or request not cleared");
  chk_dst_ack_req: assert property (
    dst_ack |-> dst_req ##1 !dst_req)
    else $error("dest ack without request or request not cleared");
  chk_ack_idle_bus: assert property (
    (src_ack || dst_ack) |-> htrans == HTRANS_IDLE)
    else $error("ack during a bus beat");

  cover property (stall);
  cover property (src_ack);
  cover property (dst_ack);
  cover property (hmastlock && htrans == HTRANS_NONSEQ);
endmodule

// >>> dv/test_dma_channel_flow_control.sv
// testbench: apb-driven channel against the peripheral end, link beats compared
`timescale 1ns/1ps
module test_dma_channel_flow_control;
  import dma_flow_pkg::*;
  logic pclk, presetn, psel, penable, pwrite, hw_mode, src_want, dst_want;
  logic [PAW-1:0] paddr;
  logic [DW-1:0] pwdata, prdata, q;
  logic pready, pslverr, arb_lock, irq, err;
  logic [1:0] m, s;
  int n_mismatch, n_checks, nwait;
  logic [34:0] got_q[$], exp_q[$];

  dma_link_if link_bus();
  dma_channel_flow_control i_dma_channel_flow_control (.pclk(pclk), .presetn(presetn),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr), .link(link_bus.ctrl_end),
    .arb_lock(arb_lock));
  dma_periph_end i_dma_periph_end (.pclk(pclk), .presetn(presetn),
    .link(link_bus.periph_end), .hw_mode(hw_mode), .src_want(src_want),
    .dst_want(dst_want), .irq(irq));
  dma_flow_chk i_dma_flow_chk (.pclk(pclk), .presetn(presetn), .htrans(link_bus.htrans),
    .haddr(link_bus.haddr), .hwrite(link_bus.hwrite), .hready(link_bus.hready),
    .hmastlock(link_bus.hmastlock), .src_req(link_bus.src_req), .dst_req(link_bus.dst_req),
    .src_ack(link_bus.src_ack), .dst_ack(link_bus.dst_ack), .arb_lock(arb_lock));

  always #2.5 pclk = ~pclk;

  // sampled mid-cycle so combinational link outputs are settled
  always @(negedge pclk) begin
    if (presetn === 1'b1 && link_bus.htrans === HTRANS_NONSEQ) begin
      if (link_bus.hready === 1'b1) begin
        got_q.push_back({arb_lock, link_bus.hmastlock, link_bus.hwrite, link_bus.haddr});
      end else begin
        nwait++;
      end
    end
  end

  // --------------------------------------------------------------------
  // tasks
  // --------------------------------------------------------------------
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", n_checks, n_mismatch);
    if (n_mismatch == 0 && n_checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask

  task automatic check(input logic [34:0] got, input logic [34:0] exp);
    n_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [PAW-1:0] a, input logic [DW-1:0] d);
    int n;
    n = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1 && n < 20) begin
      n++;
      @(posedge pclk);
    end
    if (n >= 20) begin
      n_mismatch++;
      tally_and_finish();
    end
    q = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic start_run(input logic [DW-1:0] cfg, size, src, dst, dptr);
    apb(1'b1, OFF_SRC_ADDR, src);
    apb(1'b1, OFF_DST_ADDR, dst);
    apb(1'b1, OFF_DESC_PTR, dptr);
    apb(1'b1, OFF_CFG, cfg);
    apb(1'b1, OFF_SIZE, size);
    got_q.delete();
    exp_q.delete();
    nwait = 0;
    apb(1'b1, OFF_CTRL, 32'h1);
  endtask

  // polls until done, then clears the sticky flag
  task automatic wait_done(input int nbuf);
    int n;
    n = 0;
    q = '0;
    while (q[STAT_DONE_BIT] !== 1'b1 && n < 100) begin
      apb(1'b0, OFF_STATUS, 32'h0);
      n++;
    end
    if (q[STAT_DONE_BIT] !== 1'b1) begin
      n_mismatch++;
      tally_and_finish();
    end
    check(35'(q[STAT_BUSY_BIT]), 35'h0);
    check(35'(q[STAT_BUF_LSB +: 8]), 35'(nbuf));
    apb(1'b1, OFF_STATUS, 32'h2);
  endtask

  task automatic exp_buf(input logic [31:0] src, dst, input int n, input logic sf, df, lk);
    for (int i = 0; i < n; i++) begin
      exp_q.push_back({lk, lk, 1'b0, sf ? src : src + 32'(4 * i)});
      exp_q.push_back({lk, lk, 1'b1, df ? dst : dst + 32'(4 * i)});
    end
  endtask

  task automatic cmp_beats();
    check(35'(got_q.size()), 35'(exp_q.size()));
    for (int i = 0; i < exp_q.size() && i < got_q.size(); i++) begin
      check(got_q[i], exp_q[i]);
    end
  endtask

  task automatic pulse_want(input int side);
    if (side == 0) begin
      src_want <= 1'b1;
    end else begin
      dst_want <= 1'b1;
    end
    @(posedge pclk);
    src_want <= 1'b0;
    dst_want <= 1'b0;
  endtask

  // --------------------------------------------------------------------
  // main sequence
  // --------------------------------------------------------------------
  initial begin
    pclk = 1'b0;
    presetn = 1'b0;
    {psel, penable, pwrite, hw_mode, src_want, dst_want} = '0;
    paddr = '0;
    pwdata = '0;
    n_mismatch = 0;
    n_checks = 0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, OFF_STATUS, 32'h0);
    check(35'(q), 35'(REG_RESET));
    apb(1'b0, OFF_CFG, 32'h0);
    check(35'(q), 35'(REG_RESET));
    for (int k = CFG_SRC_HS_BIT; k <= CFG_DST_HS_BIT; k++) begin
      apb(1'b1, OFF_CFG, 32'h1 << k);
      apb(1'b0, OFF_CFG, 32'h0);
      check(35'(q), 35'(32'h1 << k));
    end
    apb(1'b0, 8'h20, 32'h0);
    check(35'({err, q}), {3'h0, 32'h0} | (35'h1 << 32));
    // reload, contiguous and reload again, each with its own lock scope
    for (int i = 0; i < 3; i++) begin
      m = (i == 1) ? MB_CONTIG : MB_RELOAD;
      s = 2'(i);
      start_run(32'({s, 1'b1, s, 1'b1, 4'h0, m, m}), 32'h02020002, 32'h0, 32'h20, 32'h0);
      for (int b = 0; b < 2; b++) begin
        exp_buf(32'(m == MB_CONTIG ? 8 * b : 0), 32'h20 + 32'(m == MB_CONTIG ? 8 * b : 0),
          2, 1'b0, 1'b0, 1'b1);
      end
      wait_done(2);
      cmp_beats();
      check(35'({arb_lock, link_bus.hmastlock}), 35'h0);
    end
    // chained source, then chained dest: the item is all zero, so the chained side
    // starts at zero and the next pointer ends the transfer
    for (int c = 0; c < 2; c++) begin
      start_run(c ? 32'h9 : 32'h6, 32'h02010001, 32'h10, 32'h20, 32'h30);
      for (int k = 0; k < 3; k++) begin
        exp_q.push_back({3'h0, 32'h30 + 32'(4 * k)});
      end
      exp_buf(c ? 32'h10 : 32'h0, c ? 32'h0 : 32'h20, 1, 1'b0, 1'b0, 1'b0);
      wait_done(1);
      cmp_beats();
    end
    hw_mode <= 1'b1;
    for (int side = 0; side < 2; side++) begin
      start_run(side ? 32'ha0 : 32'h50, 32'h01020002, side ? 32'h0 : 32'h3c,
        side ? 32'h3c : 32'h20, 32'h0);
      repeat (10) @(posedge pclk);
      check(35'(got_q.size()), 35'h0);
      pulse_want(side);
      wait_done(1);
      exp_buf(side ? 32'h0 : 32'h3c, side ? 32'h3c : 32'h20, 2, side == 0, side == 1, 1'b0);
      cmp_beats();
      check(35'(nwait), 35'h0);
    end
    hw_mode <= 1'b0;
    start_run(32'h40, 32'h01020002, 32'h3c, 32'h20, 32'h0);
    repeat (10) @(posedge pclk);
    check(35'(got_q.size()), 35'h0);
    pulse_want(0);
    @(negedge pclk);
    check(35'(irq), 35'h1);
    apb(1'b1, OFF_SWREQ, 32'h1);
    wait_done(1);
    exp_buf(32'h3c, 32'h20, 2, 1'b1, 1'b0, 1'b0);
    cmp_beats();
    check(35'(irq), 35'h0);
    tally_and_finish();
  end
endmodule
